// ===== hw/smw_defs.svh
// constants of the windowed signal measure timer: offsets, fields, resets
`ifndef SMW_DEFS_SVH
`define SMW_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------
`define SMW_OFS_CTRL0      8'h00
`define SMW_OFS_PER_LOW    8'h04
`define SMW_OFS_PER_HIGH   8'h08
`define SMW_OFS_PER_UPPER  8'h0c
`define SMW_OFS_COUNTER    8'h10
`define SMW_OFS_PW_CAP     8'h14
`define SMW_OFS_PR_CAP     8'h18
`define SMW_OFS_IRQ_STAT   8'h1c
`define SMW_OFS_IRQ_MASK   8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define SMW_EN_BIT         7
`define SMW_HALT_BIT       5
`define SMW_WINDOW_POLARITY_BIT       4
`define SMW_SIGNAL_POLARITY_BIT       3
`define SMW_CLOCK_POLARITY_BIT       2
`define SMW_PS_MSB         1
`define SMW_PS_LSB         0
`define SMW_CTRL_WMASK     8'hbf

// ----------------------------------------------------------------
// interrupt status / mask fields
// ----------------------------------------------------------------
`define SMW_IRQ_MATCH      0
`define SMW_IRQ_PW         1
`define SMW_IRQ_PR         2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SMW_CTRL_RST       8'h00
`define SMW_PER_BYTE_RST   8'hff
`define SMW_IRQ_RST        3'h0
`define SMW_COUNT_ZERO     24'h000000

`endif

// ===== hw/smw_pkg.sv
// types shared by the windowed signal measure timer
package smw_pkg;

  typedef logic [31:0] smw_word_t;
  typedef logic [23:0] smw_count_t;

  // window sequencing, one-hot
  typedef enum logic [2:0] {
    SMW_OFF   = 3'b001,
    SMW_ARMED = 3'b010,
    SMW_RUN   = 3'b100
  } smw_win_state_t;

endpackage : smw_pkg

// ===== hw/smw_edge.sv
// pin synchroniser with polarity select and active-edge detection
module smw_edge (
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic pin_in,
  input  wire logic invert,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import smw_pkg::*;

  logic sync1;
  logic sync2;
  logic hist;

  // ----------------------------------------------------------------
  // two-flop synchroniser, then history of the polarised level
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      hist  <= 1'b0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      hist  <= level;
    end
  end

  // a polarity flip while the pin is steady shows as one edge
  always_comb begin
    level = sync2 ^ invert;
    rise  = level & ~hist;
    fall  = ~level & hist;
  end

  chk_edge_shape : assert property (@(posedge sys_clk) disable iff (!rstn)
    rise |=> !rise)
    else $error("edge: rise held longer than one cycle");

endmodule : smw_edge

// ===== hw/smw_timer.sv
// windowed signal measure timer with an AHB-Lite register slave
//
// Operation
// - count signal pulses only inside window
// - first active window edge starts counting
// - window end captures pulse width count
// - later window starts capture period count
// - halt set: hold at period, raise match
// - halt clear: wrap to zero, raise match
// - bit 4 inverts window polarity
// - bit 3 inverts signal polarity
// - bit 2 selects falling counting clock edge
// - prescale divides counting clock by 1,2,4,8
// - enable clear resets logic, drops clock request
// - enable clear leaves visible registers unchanged
// - 24-bit period in three bytes, ones
`include "smw_defs.svh"

module smw_timer (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic               hsel,
  input  wire smw_pkg::smw_word_t haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire smw_pkg::smw_word_t hwdata,
  input  wire logic               hready,
  output smw_pkg::smw_word_t      hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               window_input,
  input  wire logic               measured_signal_input,
  input  wire logic               count_clock_input,
  output logic                    clock_request,
  output logic                    irq
);
  import smw_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // last prescaler count before a tick for each divide code
  function automatic logic [2:0] smw_presc_limit(input logic [1:0] ps);
    case (ps)
      2'b00:   smw_presc_limit = 3'h0;
      2'b01:   smw_presc_limit = 3'h1;
      2'b10:   smw_presc_limit = 3'h3;
      default: smw_presc_limit = 3'h7;
    endcase
  endfunction : smw_presc_limit

  // ----------------------------------------------------------------
  // state declarations
  // ----------------------------------------------------------------
  logic           wr_pend;
  logic [7:0]     wr_addr;
  logic [7:0]     ctrl;
  smw_count_t     period_match_value;
  logic [2:0]     irq_stat;
  logic [2:0]     irq_mask;
  smw_win_state_t state;
  smw_count_t     measure_counter;
  smw_count_t     pulse_width_capture;
  smw_count_t     period_capture;
  logic [2:0]     presc;
  logic           pulse_pend;
  logic           next_wr_pend;
  logic [7:0]     next_wr_addr;
  smw_word_t      next_hrdata;
  logic [7:0]     next_ctrl;
  smw_count_t     next_period;
  logic [2:0]     next_irq_stat;
  logic [2:0]     next_irq_mask;
  smw_win_state_t next_state;
  smw_count_t     next_counter;
  smw_count_t     next_pw_cap;
  smw_count_t     next_pr_cap;
  logic [2:0]     next_presc;
  logic           next_pulse_pend;
  logic           accept;
  smw_word_t      rd_word;
  logic [2:0]     irq_event;
  logic           enable;
  logic           halt_at_period;
  logic           win_level;
  logic           win_rise;
  logic           win_fall;
  logic           sig_rise;
  logic           clk_rise;
  logic           tick;

  assign enable         = ctrl[`SMW_EN_BIT];
  assign halt_at_period = ctrl[`SMW_HALT_BIT];

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  // window pin, inverted when window polarity is set
  smw_edge u_win (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_in  (window_input),
    .invert  (ctrl[`SMW_WINDOW_POLARITY_BIT]),
    .level   (win_level),
    .rise    (win_rise),
    .fall    (win_fall)
  );

  // measured signal, active edge chosen by signal polarity
  smw_edge u_sig (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_in  (measured_signal_input),
    .invert  (ctrl[`SMW_SIGNAL_POLARITY_BIT]),
    .level   (),
    .rise    (sig_rise),
    .fall    ()
  );

  // counting clock, sampled; falling edge used when polarity is set
  smw_edge u_clk (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_in  (count_clock_input),
    .invert  (ctrl[`SMW_CLOCK_POLARITY_BIT]),
    .level   (),
    .rise    (clk_rise),
    .fall    ()
  );

  // prescaled tick: every 1st, 2nd, 4th or 8th selected clock edge
  assign tick = enable && clk_rise &&
                (presc == smw_presc_limit(ctrl[`SMW_PS_MSB:`SMW_PS_LSB]));

  // ----------------------------------------------------------------
  // bus slave: zero wait state, always OKAY
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;

  // read multiplexer; unmapped words read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      `SMW_OFS_CTRL0:     rd_word[7:0]  = ctrl;
      `SMW_OFS_PER_LOW:   rd_word[7:0]  = period_match_value[7:0];
      `SMW_OFS_PER_HIGH:  rd_word[7:0]  = period_match_value[15:8];
      `SMW_OFS_PER_UPPER: rd_word[7:0]  = period_match_value[23:16];
      `SMW_OFS_COUNTER:   rd_word[23:0] = measure_counter;
      `SMW_OFS_PW_CAP:    rd_word[23:0] = pulse_width_capture;
      `SMW_OFS_PR_CAP:    rd_word[23:0] = period_capture;
      `SMW_OFS_IRQ_STAT:  rd_word[2:0]  = irq_stat;
      `SMW_OFS_IRQ_MASK:  rd_word[2:0]  = irq_mask;
      default:            rd_word       = 32'h0000_0000;
    endcase
  end

  // address phase is latched; write data applies in the data phase
  always_comb begin
    next_wr_pend = accept && hwrite;
    next_wr_addr = accept ? haddr[7:0] : wr_addr;
    next_hrdata  = (accept && !hwrite) ? rd_word : hrdata;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // status set by hardware wins over a same-cycle write-one clear
  always_comb begin
    next_ctrl     = ctrl;
    next_period   = period_match_value;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat | irq_event;
    if (wr_pend) begin
      case (wr_addr)
        `SMW_OFS_CTRL0:     next_ctrl = hwdata[7:0] & `SMW_CTRL_WMASK;
        `SMW_OFS_PER_LOW:   next_period[7:0]   = hwdata[7:0];
        `SMW_OFS_PER_HIGH:  next_period[15:8]  = hwdata[7:0];
        `SMW_OFS_PER_UPPER: next_period[23:16] = hwdata[7:0];
        `SMW_OFS_IRQ_MASK:  next_irq_mask = hwdata[2:0];
        `SMW_OFS_IRQ_STAT:
          next_irq_stat = (irq_stat & ~hwdata[2:0]) | irq_event;
        default:            next_ctrl = ctrl;
      endcase
    end
  end

  // period bytes come up all ones
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl               <= `SMW_CTRL_RST;
      period_match_value <= {3{`SMW_PER_BYTE_RST}};
      irq_stat           <= `SMW_IRQ_RST;
      irq_mask           <= `SMW_IRQ_RST;
      irq                <= 1'b0;
      clock_request      <= 1'b0;
    end else begin
      ctrl               <= next_ctrl;
      period_match_value <= next_period;
      irq_stat           <= next_irq_stat;
      irq_mask           <= next_irq_mask;
      irq                <= |(irq_stat & irq_mask);
      clock_request      <= enable;
    end
  end

  // ----------------------------------------------------------------
  // measurement engine
  // ----------------------------------------------------------------
  // disabling clears only sequencing, prescaler and pending pulse; counts stay readable
  always_comb begin
    next_state      = state;
    next_counter    = measure_counter;
    next_pw_cap     = pulse_width_capture;
    next_pr_cap     = period_capture;
    next_presc      = presc;
    next_pulse_pend = pulse_pend;
    irq_event       = 3'b000;
    if (!enable) begin
      next_state      = SMW_OFF;
      next_presc      = 3'h0;
      next_pulse_pend = 1'b0;
    end else begin
      if (clk_rise) begin
        next_presc = tick ? 3'h0 : presc + 3'h1;
      end
      if (sig_rise) begin
        next_pulse_pend = 1'b1;
      end
      case (state)
        SMW_OFF: begin
          next_state = SMW_ARMED;
        end
        SMW_ARMED: begin
          if (win_rise) begin
            next_state      = SMW_RUN;
            next_counter    = `SMW_COUNT_ZERO;
            next_pulse_pend = 1'b0;
          end
        end
        SMW_RUN: begin
          if (win_rise) begin
            next_pr_cap                = measure_counter;
            irq_event[`SMW_IRQ_PR]     = 1'b1;
            next_counter               = `SMW_COUNT_ZERO;
            next_pulse_pend            = 1'b0;
          end else if (tick) begin
            next_pulse_pend = sig_rise;
            if (measure_counter == period_match_value) begin
              irq_event[`SMW_IRQ_MATCH] = 1'b1;
              if (!halt_at_period) begin
                next_counter = `SMW_COUNT_ZERO;
              end
            end else if ((pulse_pend || sig_rise) && win_level) begin
              next_counter = measure_counter + 24'h000001;
            end
          end
          if (win_fall) begin
            next_pw_cap            = measure_counter;
            irq_event[`SMW_IRQ_PW] = 1'b1;
          end
        end
        default: begin
          next_state = SMW_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state               <= SMW_OFF;
      measure_counter     <= `SMW_COUNT_ZERO;
      pulse_width_capture <= `SMW_COUNT_ZERO;
      period_capture      <= `SMW_COUNT_ZERO;
      presc               <= 3'h0;
      pulse_pend          <= 1'b0;
    end else begin
      state               <= next_state;
      measure_counter     <= next_counter;
      pulse_width_capture <= next_pw_cap;
      period_capture      <= next_pr_cap;
      presc               <= next_presc;
      pulse_pend          <= next_pulse_pend;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_match_tick;
    enable && state == SMW_RUN && tick && !win_rise &&
    measure_counter == period_match_value;
  endsequence
  sequence s_idle_tick;
    enable && state == SMW_RUN && tick && !win_rise && !win_level &&
    measure_counter != period_match_value;
  endsequence
  chk_gate_window : assert property (@(posedge sys_clk)
    disable iff (!rstn)
    s_idle_tick |=> measure_counter == $past(measure_counter))
    else $error("counter moved outside the window");
  chk_first_arm : assert property (@(posedge sys_clk)
    disable iff (!rstn) enable && state == SMW_ARMED && win_rise
    |=> state == SMW_RUN && measure_counter == 24'h000000)
    else $error("first window edge did not start counting");
  chk_width_cap : assert property (@(posedge sys_clk)
    disable iff (!rstn) enable && state == SMW_RUN && win_fall
    |=> pulse_width_capture == $past(measure_counter)
        ##1 irq_stat[`SMW_IRQ_PW])
    else $error("window end did not capture the count");
  chk_period_cap : assert property (@(posedge sys_clk)
    disable iff (!rstn) enable && state == SMW_RUN && win_rise
    |=> period_capture == $past(measure_counter) &&
        measure_counter == 24'h000000)
    else $error("window restart did not capture the period");
  chk_halt_hold : assert property (@(posedge sys_clk)
    disable iff (!rstn) s_match_tick and halt_at_period
    |=> measure_counter == $past(period_match_value) &&
        irq_stat[`SMW_IRQ_MATCH])
    else $error("halt at period did not hold and flag");
  chk_wrap_zero : assert property (@(posedge sys_clk)
    disable iff (!rstn) s_match_tick and !halt_at_period
    |=> measure_counter == 24'h000000 && irq_stat[`SMW_IRQ_MATCH])
    else $error("period match did not wrap to zero");
  chk_match_ticks : assert property (@(posedge sys_clk)
    disable iff (!rstn)
    irq_event[`SMW_IRQ_MATCH] |-> tick ##1 irq_stat[`SMW_IRQ_MATCH])
    else $error("match raised off a prescaled tick");
  chk_presc_step : assert property (@(posedge sys_clk)
    disable iff (!rstn) enable && clk_rise && !tick && $stable(ctrl)
    |=> presc == $past(presc) + 3'h1)
    else $error("prescaler skipped a counting edge");
  chk_off_reset : assert property (@(posedge sys_clk)
    disable iff (!rstn)
    !enable |=> state == SMW_OFF && presc == 3'h0 && !clock_request)
    else $error("disabled timer kept running");
  chk_off_keep : assert property (@(posedge sys_clk)
    disable iff (!rstn) !enable && !wr_pend
    |=> $stable(measure_counter) && $stable(period_capture) &&
        $stable(pulse_width_capture) && $stable(period_match_value))
    else $error("disable altered a visible register");
  chk_period_wr : assert property (@(posedge sys_clk)
    disable iff (!rstn) wr_pend && wr_addr == `SMW_OFS_PER_UPPER
    |=> period_match_value[23:16] == $past(hwdata[7:0]))
    else $error("upper period byte not written");
  chk_irq_level : assert property (@(posedge sys_clk)
    disable iff (!rstn) |(irq_stat & irq_mask) |=> irq)
    else $error("unmasked status did not raise irq");

endmodule : smw_timer

// ===== verif/smw_src.sv
// far-side model: window, measured signal and counting clock sources
module smw_src (
  input  wire logic sys_clk,
  output logic      window_input,
  output logic      measured_signal_input,
  output logic      count_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // all sources idle low and stand still until a task moves them
  initial begin
    window_input          = 1'b0;
    measured_signal_input = 1'b0;
    count_clock_input     = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold

  // each level outlasts the 2-flop sync plus edge history and capture
  task automatic win(input logic v);
    window_input <= v;
    hold(8);
  endtask : win

  task automatic sig(input logic v);
    measured_signal_input <= v;
    hold(6);
  endtask : sig

  // counting clock high and low each stay well over 2 system cycles
  task automatic cclk(input logic v);
    count_clock_input <= v;
    hold(8);
  endtask : cclk

  // one signal pulse, then n full counting clock periods
  task automatic pt(input logic act, input int n);
    sig(act);
    sig(~act);
    repeat (2 * n) cclk(~count_clock_input);
  endtask : pt
endmodule : smw_src

// ===== verif/tb_top.sv
// self-checking bench for the windowed signal measure timer
`include "smw_defs.svh"
module tb_top;
  import smw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ctl  = `SMW_OFS_CTRL0;
  localparam logic [7:0] pl   = `SMW_OFS_PER_LOW;
  localparam logic [7:0] ph   = `SMW_OFS_PER_HIGH;
  localparam logic [7:0] pu   = `SMW_OFS_PER_UPPER;
  localparam logic [7:0] cnt  = `SMW_OFS_COUNTER;
  localparam logic [7:0] pwc  = `SMW_OFS_PW_CAP;
  localparam logic [7:0] prc  = `SMW_OFS_PR_CAP;
  localparam logic [7:0] stat = `SMW_OFS_IRQ_STAT;
  localparam logic [7:0] msk  = `SMW_OFS_IRQ_MASK;

  logic       sys_clk = 1'b0;
  logic       rstn, hsel, hwrite, hreadyout, hresp, clock_request, irq;
  logic       win_pin, sig_pin, cclk_pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  smw_word_t  haddr, hwdata, hrdata;
  int         err_count = 0;
  int         cmp_count = 0;

  always #20 sys_clk = ~sys_clk;

  smw_timer dut (
    .sys_clk              (sys_clk),
    .rstn                 (rstn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hreadyout),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .window_input         (win_pin),
    .measured_signal_input(sig_pin),
    .count_clock_input    (cclk_pin),
    .clock_request        (clock_request),
    .irq                  (irq)
  );

  smw_src src (
    .sys_clk              (sys_clk),
    .window_input         (win_pin),
    .measured_signal_input(sig_pin),
    .count_clock_input    (cclk_pin)
  );

  // ----------------------------------------------------------------
  // bus master and checking tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // next rising edge with hready high; a stuck slave ends the run
  task automatic wt;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        err_count++;
        close_out();
      end
      @(posedge sys_clk);
    end
  endtask : wt

  // one single transfer, then an idle cycle so reads see fresh values
  task automatic bus(input logic [7:0] a, input logic w,
                     input smw_word_t d, output smw_word_t q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    wt();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wt();
    q = hrdata;
    chk("hresp okay", 32'h00000000, {31'h0, hresp});
    @(posedge sys_clk);
  endtask : bus

  // select or transfer type low: the slave must ignore the cycle
  task automatic nosel(input logic [7:0] a, input smw_word_t d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'b00;
    hwrite <= 1'b1;
    hwdata <= d;
    @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'b10;
    @(posedge sys_clk);
    htrans <= 2'b00;
    @(posedge sys_clk);
  endtask : nosel

  task automatic chk(input string nm, input smw_word_t e,
                     input smw_word_t g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input smw_word_t d);
    smw_word_t q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input smw_word_t e,
                    input string nm);
    smw_word_t q;
    bus(a, 1'b0, 32'h00000000, q);
    chk(nm, e, q);
  endtask : rc

  // outputs are sampled mid-cycle, where registered values have landed
  task automatic pins(input logic cr, input logic iq, input string nm);
    @(negedge sys_clk);
    chk(nm, {30'h0, cr, iq}, {30'h0, clock_request, irq});
    @(posedge sys_clk);
  endtask : pins

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int p;
    rstn   = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h00000000;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rc(ctl, 32'h00000000, "ctrl reset");
    rc(pl, 32'h000000ff, "period low reset");
    rc(ph, 32'h000000ff, "period high reset");
    rc(pu, 32'h000000ff, "period upper reset");
    rc(stat, 32'h00000000, "status reset");
    rc(msk, 32'h00000000, "mask reset");
    wr(8'h24, 32'hffffffff);
    rc(8'h24, 32'h00000000, "unmapped read");
    wr(ctl, 32'h0000007f);
    rc(ctl, 32'h0000003f, "ctrl reserved bit");
    nosel(ctl, 32'h00000080);
    rc(ctl, 32'h0000003f, "unselected write ignored");
    wr(ph, 32'h0000005a);
    rc(ph, 32'h0000005a, "period high rw");
    wr(ph, 32'h000000ff);
    wr(ctl, 32'h00000000);
    pins(1'b0, 1'b0, "idle pins");
    $display("test registers done");

    // window start, in-window counting, both captures, irq
    wr(msk, 32'h00000004);
    wr(ctl, 32'h00000080);
    pins(1'b1, 1'b0, "enabled pins");
    src.win(1'b1);
    repeat (3) src.pt(1'b1, 1);
    rc(cnt, 32'h00000003, "count in window");
    src.win(1'b0);
    rc(pwc, 32'h00000003, "pulse width capture");
    src.pt(1'b1, 1);
    rc(cnt, 32'h00000003, "no count outside window");
    src.win(1'b1);
    rc(prc, 32'h00000003, "period capture");
    rc(cnt, 32'h00000000, "restart after period");
    rc(stat, 32'h00000006, "capture status");
    pins(1'b1, 1'b1, "capture irq");
    wr(stat, 32'h00000006);
    rc(stat, 32'h00000000, "status cleared");
    pins(1'b1, 1'b0, "irq cleared");
    $display("test window done");

    // each prescale code needs exactly its count of clock edges
    for (p = 0; p < 4; p++) begin
      wr(ctl, 32'h00000000);
      src.win(1'b0);
      wr(ctl, smw_word_t'(32'h80 + p));
      src.win(1'b1);
      src.pt(1'b1, (1 << p) - 1);
      rc(cnt, 32'h00000000, "prescale short");
      src.pt(1'b1, 1);
      rc(cnt, 32'h00000001, "prescale tick");
    end
    wr(ctl, 32'h00000000);
    pins(1'b0, 1'b0, "disabled pins");
    src.pt(1'b1, 1);
    rc(cnt, 32'h00000001, "counter kept");
    rc(pwc, 32'h00000003, "capture kept");
    $display("test prescale done");

    // inverted window, single falling signal edge, falling clock edge
    src.sig(1'b1);
    wr(ctl, 32'h0000009c);
    src.win(1'b0);
    src.sig(1'b0);
    src.cclk(1'b1);
    rc(cnt, 32'h00000000, "rising edge ignored");
    src.cclk(1'b0);
    rc(cnt, 32'h00000001, "falling edge counts");
    src.win(1'b1);
    rc(pwc, 32'h00000001, "low window end");
    wr(ctl, 32'h00000000);
    src.sig(1'b0);
    src.win(1'b0);
    $display("test polarity done");

    // period match: full width compare, halt, then wrap
    wr(stat, 32'h00000007);
    wr(pl, 32'h00000002);
    wr(ph, 32'h00000000);
    wr(pu, 32'h00000001);
    wr(ctl, 32'h000000a0);
    src.win(1'b1);
    repeat (3) src.pt(1'b1, 1);
    rc(cnt, 32'h00000003, "upper byte compared");
    wr(pu, 32'h00000000);
    wr(pl, 32'h00000003);
    repeat (2) src.pt(1'b1, 1);
    rc(cnt, 32'h00000003, "halt at period");
    rc(stat, 32'h00000001, "match status");
    wr(msk, 32'h00000007);
    pins(1'b1, 1'b1, "match irq");
    wr(stat, 32'h00000001);
    wr(ctl, 32'h00000080);
    src.pt(1'b1, 1);
    rc(cnt, 32'h00000000, "wrap to zero");
    rc(stat, 32'h00000001, "wrap match status");
    $display("test period done");

    // a second reset brings the period bytes back to all ones
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    pins(1'b0, 1'b0, "reset pins");
    rc(pu, 32'h000000ff, "period upper after reset");
    rc(pl, 32'h000000ff, "period low after reset");
    rc(cnt, 32'h00000000, "counter after reset");
    $display("test reset done");
    close_out();
  end
endmodule : tb_top
